// file: core/spwp_top.sv
// How it works
// R01 - works with host clock mode 0 or 3
// R02 - input bits taken on rising serial clock
// R03 - output bits change on falling serial clock
// R04 - dual read drives both data lanes
// R05 - write enable command sets latch flag
// R06 - latch clears: reset, disable, writes complete
// R07 - deep power-down ignores all but release
// R08 - status word field layout, two read-only
// R09 - busy flag high during internal operations
// R10 - latch low rejects status write, program, erase
// R11 - region bits change only by status write
// R12 - program/erase into protected region refused
// R13 - whole erase only with region bits zero
// R14 - region decode for large variant
// R15 - region decode for small variant
// R16 - region bits frozen when hardware protected
// R17 - lock bit low: write needs latch only
// R18 - lock high, guard low: writes refused
// R19 - lock high, guard high: write after enable
// R20 - write commands need whole bytes
// R21 - write disable ignored while busy
// R22 - host sends enable before status write
// R23 - block overlapping protection left untouched
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "spwp_cfg.svh"

module spwp_top #(
  parameter int PROG_CYC  = `SPWP_T_PROG_NS / `SPWP_CLK_NS,
  parameter int SECT_CYC  = `SPWP_T_SECT_NS / `SPWP_CLK_NS,
  parameter int B32_CYC   = `SPWP_T_B32_NS / `SPWP_CLK_NS,
  parameter int B64_CYC   = `SPWP_T_B64_NS / `SPWP_CLK_NS,
  parameter int CHIP_CYC  = `SPWP_T_CHIP_NS / `SPWP_CLK_NS,
  parameter int WSTAT_CYC = `SPWP_T_WSTAT_NS / `SPWP_CLK_NS
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // register bus
  input  wire spwp_pkg::spwp_axi_req_t axi_req,
  output spwp_pkg::spwp_axi_rsp_t      axi_rsp,
  // serial pins
  input  wire spwp_pkg::spwp_pin_in_t  pin_in,
  output spwp_pkg::spwp_pin_out_t      pin_out,
  // array side
  input  wire logic [7:0]              mem_rdata,
  output spwp_pkg::spwp_op_t           op
);

  typedef struct packed {
    logic [1:0]              s_sclk;
    logic [1:0]              s_cs;
    logic [1:0]              s_d0;
    logic [1:0]              s_wp;
    logic                    sclk_d;
    logic                    cs_d;
    logic [15:0]             cnt;
    logic [31:0]             shf;
    logic [7:0]              opc;
    logic [23:0]             addr;
    logic [7:0]              wbyte;
    logic                    lock;
    logic [2:0]              rsel;
    logic                    latch;
    spwp_pkg::spwp_eng_t     eng;
    logic [27:0]             tmr;
    logic [7:0]              pend;
    logic [7:0]              pend_stat;
    logic                    dpd;
    logic                    var64;
    logic [7:0]              last_op;
    logic                    last_ok;
    logic                    last_ref;
    logic                    aw_hold;
    logic [7:0]              aw_addr;
    logic                    w_hold;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    spwp_pkg::spwp_axi_rsp_t rsp;
    spwp_pkg::spwp_pin_out_t pins;
    spwp_pkg::spwp_op_t      op;
  } spwp_state_t;

  spwp_state_t st;
  spwp_state_t next_st;

  logic        rise;
  logic        fall;
  logic        cs_low;
  logic        cs_up;
  logic        bit_in;
  logic [7:0]  stat;
  logic [23:0] lim;
  logic        byte_ok;
  logic        hw_lock;
  logic        can_wr;
  logic        accept;
  logic        refuse;
  logic [27:0] load;
  logic [23:0] base;

  // R14 R15 region decode
  always_comb begin
    if (st.var64) begin
      unique casez (st.rsel)
        3'b000: lim = `SPWP_LIM_NONE;
        3'b001: lim = `SPWP_LIM_S1;
        3'b010: lim = `SPWP_LIM_S2;
        3'b011: lim = `SPWP_LIM_S3;
        3'b1??: lim = `SPWP_LIM_SALL;
      endcase
    end else begin
      unique casez (st.rsel)
        3'b000: lim = `SPWP_LIM_NONE;
        3'b001: lim = `SPWP_LIM_L1;
        3'b010: lim = `SPWP_LIM_L2;
        3'b011: lim = `SPWP_LIM_L3;
        3'b100: lim = `SPWP_LIM_L4;
        3'b101: lim = `SPWP_LIM_LALL;
        3'b11?: lim = `SPWP_LIM_LALL;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    accept  = 1'b0;
    refuse  = 1'b0;
    load    = '0;
    base    = '0;
    // pins through two flops
    next_st.s_sclk = {st.s_sclk[0], pin_in.sclk};
    next_st.s_cs   = {st.s_cs[0], pin_in.cs_n};
    next_st.s_d0   = {st.s_d0[0], pin_in.lane0_in};
    next_st.s_wp   = {st.s_wp[0], pin_in.wp_n};
    next_st.sclk_d = st.s_sclk[1];
    next_st.cs_d   = st.s_cs[1];
    // R01 edges found whatever the idle level
    rise    = st.s_sclk[1] & ~st.sclk_d;
    fall    = ~st.s_sclk[1] & st.sclk_d;
    cs_low  = ~st.s_cs[1];
    cs_up   = st.s_cs[1] & ~st.cs_d;
    bit_in  = st.s_d0[1];
    byte_ok = (st.cnt[2:0] == 3'b000);
    // R08 status word
    stat    = {st.lock, 2'b00, st.rsel, st.latch, st.eng == spwp_pkg::ENG_BUSY};
    // R18 hardware protected condition
    hw_lock = st.lock & ~st.s_wp[1];
    // R10 R17 R19 write gate
    can_wr  = st.latch & (st.eng == spwp_pkg::ENG_IDLE);
    next_st.op.start = 1'b0;

    if (cs_low & st.cs_d) begin
      next_st.cnt = '0;
    end
    // R02 shift on rising edge
    if (cs_low & rise) begin
      next_st.shf = {st.shf[30:0], bit_in};
      if (st.cnt != `SPWP_CNT_MAX) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
      if (st.cnt == `SPWP_CNT_OPC - 16'h0001) begin
        next_st.opc = {st.shf[6:0], bit_in};
      end
      if (st.cnt == `SPWP_CNT_WSTAT - 16'h0001) begin
        next_st.wbyte = {st.shf[6:0], bit_in};
      end
      if (st.cnt == `SPWP_CNT_ADDR - 16'h0001) begin
        next_st.addr = {st.shf[22:0], bit_in};
      end
    end
    // R03 drive on falling edge
    if (cs_low & fall & ~st.dpd & (st.cnt >= `SPWP_CNT_OPC)) begin
      unique case (st.opc)
        `SPWP_CMD_RSTAT: begin
          next_st.pins.lane1_out = stat[~st.cnt[2:0]];
          next_st.pins.lane1_oe  = 1'b1;
        end
        `SPWP_CMD_READ: begin
          if (st.cnt >= `SPWP_CNT_ADDR) begin
            next_st.pins.lane1_out = mem_rdata[~st.cnt[2:0]];
            next_st.pins.lane1_oe  = 1'b1;
          end
        end
        `SPWP_CMD_FREAD: begin
          if (st.cnt >= `SPWP_CNT_FAST) begin
            next_st.pins.lane1_out = mem_rdata[~st.cnt[2:0]];
            next_st.pins.lane1_oe  = 1'b1;
          end
        end
        // R04 two bits per clock
        `SPWP_CMD_DREAD: begin
          if (st.cnt >= `SPWP_CNT_FAST) begin
            next_st.pins.lane1_out = mem_rdata[{~st.cnt[1:0], 1'b1}];
            next_st.pins.lane0_out = mem_rdata[{~st.cnt[1:0], 1'b0}];
            next_st.pins.lane1_oe  = 1'b1;
            next_st.pins.lane0_oe  = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // frame end executes
    if (cs_up) begin
      next_st.pins.lane0_oe = 1'b0;
      next_st.pins.lane1_oe = 1'b0;
      if (st.cnt >= `SPWP_CNT_OPC) begin
        // R07 only release acts in power-down
        if (st.opc == `SPWP_CMD_REL) begin
          next_st.dpd = 1'b0;
        end else if (!st.dpd) begin
          unique case (st.opc)
            // R05 set latch
            `SPWP_CMD_WEN: begin
              if (st.cnt == `SPWP_CNT_OPC && st.eng == spwp_pkg::ENG_IDLE) begin
                next_st.latch = 1'b1;
              end
            end
            // R06 R21 clear latch when idle
            `SPWP_CMD_WDIS: begin
              if (st.cnt == `SPWP_CNT_OPC && st.eng == spwp_pkg::ENG_IDLE) begin
                next_st.latch = 1'b0;
              end
            end
            // R16 R18 R20 status write gate
            `SPWP_CMD_WSTAT: begin
              if (st.cnt == `SPWP_CNT_WSTAT && can_wr && !hw_lock) begin
                accept = 1'b1;
                load   = 28'(WSTAT_CYC - 1);
              end else begin
                refuse = 1'b1;
              end
            end
            // R12 R20 program outside region
            `SPWP_CMD_PROG: begin
              if (st.cnt >= `SPWP_CNT_PROG && byte_ok && can_wr && st.addr >= lim) begin
                accept = 1'b1;
                load   = 28'(PROG_CYC - 1);
              end else begin
                refuse = 1'b1;
              end
            end
            `SPWP_CMD_SECT: begin
              base = st.addr & `SPWP_MASK_SECT;
              if (st.cnt == `SPWP_CNT_ADDR && can_wr && base >= lim) begin
                accept = 1'b1;
                load   = 28'(SECT_CYC - 1);
              end else begin
                refuse = 1'b1;
              end
            end
            // R23 block start below limit overlaps
            `SPWP_CMD_BLK32: begin
              base = st.addr & `SPWP_MASK_B32;
              if (st.cnt == `SPWP_CNT_ADDR && can_wr && base >= lim) begin
                accept = 1'b1;
                load   = 28'(B32_CYC - 1);
              end else begin
                refuse = 1'b1;
              end
            end
            `SPWP_CMD_BLK64: begin
              base = st.addr & `SPWP_MASK_B64;
              if (st.cnt == `SPWP_CNT_ADDR && can_wr && base >= lim) begin
                accept = 1'b1;
                load   = 28'(B64_CYC - 1);
              end else begin
                refuse = 1'b1;
              end
            end
            // R13 whole erase only unprotected
            `SPWP_CMD_CHIPA, `SPWP_CMD_CHIPB: begin
              if (st.cnt == `SPWP_CNT_OPC && can_wr && st.rsel == 3'b000) begin
                accept = 1'b1;
                load   = 28'(CHIP_CYC - 1);
              end else begin
                refuse = 1'b1;
              end
            end
            `SPWP_CMD_DPD: begin
              if (st.cnt == `SPWP_CNT_OPC && st.eng == spwp_pkg::ENG_IDLE) begin
                next_st.dpd = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      if (accept | refuse) begin
        next_st.last_op  = st.opc;
        next_st.last_ok  = accept;
        next_st.last_ref = refuse;
      end
      // R09 busy starts
      if (accept) begin
        next_st.eng       = spwp_pkg::ENG_BUSY;
        next_st.tmr       = load;
        next_st.pend      = st.opc;
        next_st.pend_stat = st.wbyte;
        next_st.op.start  = 1'b1;
        next_st.op.code   = st.opc;
        next_st.op.addr   = st.addr;
      end
    end

    // R09 busy ends
    if (st.eng == spwp_pkg::ENG_BUSY) begin
      if (st.tmr == '0) begin
        next_st.eng   = spwp_pkg::ENG_IDLE;
        // R06 latch cleared on completion
        next_st.latch = 1'b0;
        // R11 region bits from status write
        if (st.pend == `SPWP_CMD_WSTAT) begin
          next_st.lock = st.pend_stat[`SPWP_ST_LOCK];
          next_st.rsel = st.pend_stat[`SPWP_ST_RS_HI:`SPWP_ST_RS_LO];
        end
      end else begin
        next_st.tmr = st.tmr - 28'h0000001;
      end
    end

    // bus write side
    if (axi_req.awvalid & st.rsp.awready) begin
      next_st.aw_hold     = 1'b1;
      next_st.aw_addr     = axi_req.awaddr;
      next_st.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid & st.rsp.wready) begin
      next_st.w_hold     = 1'b1;
      next_st.w_data     = axi_req.wdata;
      next_st.w_strb     = axi_req.wstrb;
      next_st.rsp.wready = 1'b0;
    end
    if (st.aw_hold & st.w_hold & ~st.rsp.bvalid) begin
      next_st.aw_hold    = 1'b0;
      next_st.w_hold     = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = `SPWP_RESP_OKAY;
      unique case (st.aw_addr)
        `SPWP_REG_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.var64 = st.w_data[0];
          end
        end
        `SPWP_REG_STATUS, `SPWP_REG_EVENT: begin
        end
        default: next_st.rsp.bresp = `SPWP_RESP_SLV;
      endcase
    end
    if (st.rsp.bvalid & axi_req.bready) begin
      next_st.rsp.bvalid  = 1'b0;
      next_st.rsp.awready = 1'b1;
      next_st.rsp.wready  = 1'b1;
    end

    // bus read side
    if (axi_req.arvalid & st.rsp.arready) begin
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid  = 1'b1;
      next_st.rsp.rresp   = `SPWP_RESP_OKAY;
      unique case (axi_req.araddr)
        `SPWP_REG_STATUS: next_st.rsp.rdata = {23'h000000, st.dpd, stat};
        `SPWP_REG_CTRL:   next_st.rsp.rdata = {31'h00000000, st.var64};
        `SPWP_REG_EVENT:  next_st.rsp.rdata = {22'h000000, st.last_ref, st.last_ok, st.last_op};
        default: begin
          next_st.rsp.rdata = '0;
          next_st.rsp.rresp = `SPWP_RESP_SLV;
        end
      endcase
    end
    if (st.rsp.rvalid & axi_req.rready) begin
      next_st.rsp.rvalid  = 1'b0;
      next_st.rsp.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st             <= '0;
      st.s_cs        <= 2'b11;
      st.cs_d        <= 1'b1;
      st.s_wp        <= 2'b11;
      st.rsp.awready <= 1'b1;
      st.rsp.wready  <= 1'b1;
      st.rsp.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign axi_rsp = st.rsp;
  assign pin_out = st.pins;
  assign op      = st.op;

endmodule : spwp_top

// file: core/spwp_cfg.svh
`ifndef SPWP_CFG_SVH
`define SPWP_CFG_SVH

// command codes
`define SPWP_CMD_WEN    8'h06
`define SPWP_CMD_WDIS   8'h04
`define SPWP_CMD_RSTAT  8'h05
`define SPWP_CMD_WSTAT  8'h01
`define SPWP_CMD_READ   8'h03
`define SPWP_CMD_FREAD  8'h0b
`define SPWP_CMD_DREAD  8'h3b
`define SPWP_CMD_PROG   8'h02
`define SPWP_CMD_SECT   8'h20
`define SPWP_CMD_BLK32  8'h52
`define SPWP_CMD_BLK64  8'hd8
`define SPWP_CMD_CHIPA  8'h60
`define SPWP_CMD_CHIPB  8'hc7
`define SPWP_CMD_DPD    8'hb9
`define SPWP_CMD_REL    8'hab

// bit counts within a frame
`define SPWP_CNT_MAX    16'hffff
`define SPWP_CNT_OPC    16'h0008
`define SPWP_CNT_WSTAT  16'h0010
`define SPWP_CNT_ADDR   16'h0020
`define SPWP_CNT_FAST   16'h0028
`define SPWP_CNT_PROG   16'h0028

// status word layout
`define SPWP_ST_LOCK    7
`define SPWP_ST_RS_HI   4
`define SPWP_ST_RS_LO   2

// protected limits, exclusive end address
`define SPWP_LIM_NONE   24'h000000
`define SPWP_LIM_L1     24'h01e000
`define SPWP_LIM_L2     24'h01c000
`define SPWP_LIM_L3     24'h018000
`define SPWP_LIM_L4     24'h010000
`define SPWP_LIM_LALL   24'h020000
`define SPWP_LIM_S1     24'h00e000
`define SPWP_LIM_S2     24'h00c000
`define SPWP_LIM_S3     24'h008000
`define SPWP_LIM_SALL   24'h010000
`define SPWP_MASK_SECT  24'hfff000
`define SPWP_MASK_B32   24'hff8000
`define SPWP_MASK_B64   24'hff0000

// timing, in ns
`define SPWP_CLK_NS     4
`define SPWP_T_PROG_NS  600000
`define SPWP_T_SECT_NS  60000000
`define SPWP_T_B32_NS   200000000
`define SPWP_T_B64_NS   350000000
`define SPWP_T_CHIP_NS  1000000000
`define SPWP_T_WSTAT_NS 5000000

// register map
`define SPWP_REG_STATUS 8'h00
`define SPWP_REG_CTRL   8'h04
`define SPWP_REG_EVENT  8'h08
`define SPWP_RESP_OKAY  2'b00
`define SPWP_RESP_SLV   2'b10

`endif

// file: core/spwp_pkg.sv
package spwp_pkg;

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_BUSY = 1'b1
  } spwp_eng_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } spwp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } spwp_axi_rsp_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic lane0_in;
    logic wp_n;
  } spwp_pin_in_t;

  typedef struct packed {
    logic lane0_out;
    logic lane0_oe;
    logic lane1_out;
    logic lane1_oe;
  } spwp_pin_out_t;

  typedef struct packed {
    logic        start;
    logic [7:0]  code;
    logic [23:0] addr;
  } spwp_op_t;

endpackage : spwp_pkg

// file: verif/spwp_chk.sv
`timescale 1ns/1ps
module spwp_chk (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst,
  // bus, pins, array side
  input wire spwp_pkg::spwp_axi_req_t axi_req,
  input wire spwp_pkg::spwp_axi_rsp_t axi_rsp,
  input wire spwp_pkg::spwp_pin_in_t  pin_in,
  input wire spwp_pkg::spwp_pin_out_t pin_out,
  input wire spwp_pkg::spwp_op_t      op
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence ar_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence r_take;
    axi_rsp.rvalid && axi_req.rready;
  endsequence
  AST_R_ANSWER: assert property (ar_take |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer late");
  AST_R_CLOSE: assert property (r_take |=> !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read answer not closed");
  AST_AW_BLOCK: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
    else $error("second write taken");
  AST_START_PULSE: assert property (op.start |=> !op.start)
    else $error("start longer than one cycle");
  AST_START_DESEL: assert property (op.start |-> pin_in.cs_n)
    else $error("start while selected");
  AST_OUT_FALL: assert property (pin_out.lane1_oe && $past(pin_out.lane1_oe) && $changed(pin_out.lane1_out)
    |-> !pin_in.sclk)
    else $error("output changed with clock high");
  AST_DUAL_PAIR: assert property (pin_out.lane0_oe |-> pin_out.lane1_oe)
    else $error("lane0 driven alone");
  AST_IDLE_QUIET: assert property (pin_in.cs_n [*8] |-> !pin_out.lane1_oe && !pin_out.lane0_oe)
    else $error("lanes driven while deselected");
endmodule : spwp_chk

// file: verif/spwp_host.sv
`timescale 1ns/1ps
module spwp_host (
  // serial lines
  output logic      sclk,
  output logic      cs_n,
  output logic      host_d,
  input  wire logic lane0,
  input  wire logic lane1
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    host_d = 1'b0;
  end
  // whole bytes unless asked; idle level sets mode
  task automatic frame(input logic [47:0] tx, input int n, input int m, input bit dual, input bit mode3,
                       output logic [7:0] rx);
    int i;
    rx = 8'h00;
    sclk = mode3;
    #7.1 cs_n = 1'b0;
    for (i = 0; i < n + m; i++) begin
      #10 sclk = 1'b0;
      host_d = (i < n) ? tx[n-1-i] : ~host_d;
      #52.5 sclk = 1'b1;
      if (i >= n) rx = dual ? {rx[5:0], lane1, lane0} : {rx[6:0], lane1};
      #52.5;
    end
    #10 sclk = mode3;
    #30 cs_n = 1'b1;
    host_d = ~host_d;
    #40;
  endtask : frame
endmodule : spwp_host

// file: verif/tb_spi_flash_write_protection.sv
`timescale 1ns/1ps
module tb_spi_flash_write_protection;
  localparam int BC = 100;
  logic                    clk_sys   = 1'b0;
  logic                    rst       = 1'b1;
  spwp_pkg::spwp_axi_req_t req       = '0;
  spwp_pkg::spwp_axi_rsp_t rsp;
  spwp_pkg::spwp_pin_out_t pout;
  spwp_pkg::spwp_pin_in_t  pin_in;
  spwp_pkg::spwp_op_t      op;
  logic [7:0]              mem_rdata = 8'h00;
  logic                    wp_n      = 1'b1;
  logic                    sclk;
  logic                    cs_n;
  logic                    host_d;
  logic [31:0]             seed      = 32'h3cd538d7;
  logic [31:0]             q;
  logic [31:0]             r;
  logic [1:0]              resp;
  logic [7:0]              rx;
  logic [7:0]              cmd;
  logic [7:0]              seen_code = 8'h00;
  logic [23:0]             seen_addr = 24'h000000;
  int                      fails = 0, samples_checked = 0, cyc = 0, starts = 0;
  int                      lock = 0, rs = 0, write_enable_latch_flag = 0, var64 = 0, dpd = 0, acc = 0;
  int                      v, c, a, lm, mk;
  wire                     lane0 = pout.lane0_oe ? pout.lane0_out : host_d;
  wire                     lane1 = pout.lane1_oe ? pout.lane1_out : ~host_d;
  assign pin_in = {sclk, cs_n, lane0, wp_n};

  spwp_top #(.PROG_CYC(BC), .SECT_CYC(BC), .B32_CYC(BC), .B64_CYC(BC), .CHIP_CYC(BC), .WSTAT_CYC(BC)) uut (
    .clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pout),
    .mem_rdata(mem_rdata), .op(op));
  spwp_host host (.sclk(sclk), .cs_n(cs_n), .host_d(host_d), .lane0(lane0), .lane1(lane1));

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (op.start === 1'b1) begin
      starts++;
      seen_code = op.code;
      seen_addr = op.addr;
    end
    if (cyc == 90000) begin
      fails++;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int lim(int k);
    int t64[8]  = '{0, 24'h00e000, 24'h00c000, 24'h008000, 24'h010000, 24'h010000, 24'h010000, 24'h010000};
    int t128[8] = '{0, 24'h01e000, 24'h01c000, 24'h018000, 24'h010000, 24'h020000, 24'h020000, 24'h020000};
    return var64 ? t64[k] : t128[k];
  endfunction : lim
  function automatic logic [31:0] ew();
    return {23'h0, dpd[0], lock[0], 2'b00, rs[2:0], write_enable_latch_flag[0], 1'b0};
  endfunction : ew
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi(input bit wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] qo,
                     output logic [1:0] ro);
    @(posedge clk_sys);
    req.awvalid <= wr;
    req.wvalid  <= wr;
    req.arvalid <= !wr;
    req.awaddr  <= ad;
    req.araddr  <= ad;
    req.wdata   <= d;
    req.bready  <= wr;
    req.rready  <= !wr;
    do begin
      @(posedge clk_sys);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!(rsp.bvalid && req.bready) && !(rsp.rvalid && req.rready));
    ro = wr ? rsp.bresp : rsp.rresp;
    qo = rsp.rdata;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask : axi
  task automatic spi(input logic [47:0] tx, input int n, input int m, input bit dual);
    logic [31:0] k;
    k = rnd();
    host.frame(tx, n, m, dual, k[0], rx);
  endtask : spi
  task automatic st();
    axi(0, 8'h00, 0, q, resp);
    chk(q, ew());
  endtask : st
  task automatic st_spi();
    logic [31:0] e;
    e = ew();
    spi(48'h05, 8, 8, 0);
    chk({24'h0, rx}, {24'h0, e[7:0]});
  endtask : st_spi
  task automatic idle();
    int k;
    for (k = 0; k < 400; k++) begin
      axi(0, 8'h00, 0, q, resp);
      if (q[0] === 1'b0) break;
    end
  endtask : idle
  task automatic wen();
    spi(48'h06, 8, 0, 0);
    if (!dpd) write_enable_latch_flag = 1;
  endtask : wen
  task automatic wcmd(input logic [47:0] tx, input int n, input bit ok);
    bit go;
    go = ok && write_enable_latch_flag;
    spi(tx, n, 0, 0);
    axi(0, 8'h08, 0, q, resp);
    chk(q, {22'h0, !go, go, tx[n-1 -: 8]});
    axi(0, 8'h00, 0, q, resp);
    chk({31'h0, q[0]}, {31'h0, go});
    idle();
    if (go) begin
      acc++;
      write_enable_latch_flag = 0;
      chk({24'h0, seen_code}, {24'h0, tx[n-1 -: 8]});
    end
    if (go && n == 32) begin
      chk({8'h0, seen_addr}, {8'h0, tx[23:0]});
    end
    if (go && n == 16) begin
      lock = tx[7];
      rs = tx[4:2];
    end
    st();
  endtask : wcmd
  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  initial begin
    req.wstrb = 4'hf;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    st();
    axi(0, 8'h1c, 0, q, resp);
    chk({30'h0, resp}, 32'h2);
    axi(1, 8'h00, 32'hff, q, resp);
    st_spi();
    wcmd({8'h02, 24'h000100, 8'h5a}, 40, 1);
    spi(48'h0c, 9, 0, 0);
    st_spi();
    wen();
    st_spi();
    spi(48'h04, 8, 0, 0);
    write_enable_latch_flag = 0;
    st_spi();
    for (v = 0; v < 2; v++) begin
      axi(1, 8'h04, v, q, resp);
      chk({30'h0, resp}, 32'h0);
      axi(0, 8'h04, 0, q, resp);
      chk(q, v);
      var64 = v;
      for (c = 0; c < 8; c++) begin
        r = rnd();
        wp_n <= r[1];
        wen();
        wcmd({32'h0, 8'h01, 3'b000, c[2:0], 2'b00}, 16, 1);
        wen();
        lm = lim(c);
        cmd = r[2] ? (r[13] ? 8'hd8 : 8'h52) : 8'h20;
        mk = r[2] ? (r[13] ? 24'hff0000 : 24'hff8000) : 24'hfff000;
        a = (lm == 0) ? 0 : (r[12] || lm == (var64 ? 24'h010000 : 24'h020000)) ? lm - 24'h001000 : lm;
        a = a | r[11:0];
        wcmd({16'h0, cmd, a[23:0]}, 32, (a & mk) >= lm);
        wen();
        wcmd({40'h0, r[3] ? 8'hc7 : 8'h60}, 8, c == 0);
      end
    end
    wp_n <= 1'b1;
    wen();
    wcmd(48'h0180, 16, 1);
    wp_n <= 1'b0;
    wen();
    wcmd(48'h011c, 16, 0);
    wp_n <= 1'b1;
    wen();
    wcmd(48'h0104, 16, 1);
    r = rnd();
    mem_rdata <= r[7:0];
    spi({8'h3b, 24'h000010, 8'h00}, 40, 4, 1);
    chk({24'h0, rx}, {24'h0, r[7:0]});
    spi({8'h0b, 24'h000010, 8'h00}, 40, 8, 0);
    chk({24'h0, rx}, {24'h0, r[7:0]});
    spi({16'h0, 8'h03, 24'h000010}, 32, 8, 0);
    chk({24'h0, rx}, {24'h0, r[7:0]});
    spi(48'hb9, 8, 0, 0);
    dpd = 1;
    wen();
    st();
    spi(48'hab, 8, 0, 0);
    dpd = 0;
    st();
    chk(starts, acc);
    give_verdict();
  end
endmodule : tb_spi_flash_write_protection

bind spwp_top spwp_chk chk_i (
  .clk_sys(clk_sys), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_in(pin_in), .pin_out(pin_out),
  .op(op));
